// File: irq_prio_pkg.sv
// Overview of operation
// RL1: Enable register bits 15-4 and 0 read zero
// RL2: Enable bits 3,2,1: checksum, serial2, serial1 errors
// RL3: Priority 111 highest, 001 lowest active level
// RL4: Priority 000 disables the source entirely
// RL5: Enables reset zero, priority fields reset 100
// RL6: Group0 fields at 14-12,10-8,6-4,2-0
// RL7: Group1 fields at 14-12,10-8,6-4; rest zero
// RL8: Group2 fields at 14-12,10-8,6-4,2-0
// RL9: Group3 bits 15-7 zero; fields 6-4, 2-0
// RL10: Group4 fields at 14-12,10-8,6-4,2-0
// RL11: Present flagged, enabled, nonzero; highest level wins
// RL12: Unimplemented bits ignore writes; write lands next edge
package irq_prio_pkg;
  localparam int          ADDR_W       = 12;
  localparam int          NUM_SRC      = 20;
  localparam int          NUM_PRIO_SRC = 17;
  localparam int          ID_W         = 5;
  // Byte offsets of the word-aligned registers
  localparam logic [11:0] OFF_EN4      = 12'h000;
  localparam logic [11:0] OFF_PRIO0    = 12'h004;
  localparam logic [11:0] OFF_PRIO1    = 12'h008;
  localparam logic [11:0] OFF_PRIO2    = 12'h00C;
  localparam logic [11:0] OFF_PRIO3    = 12'h010;
  localparam logic [11:0] OFF_PRIO4    = 12'h014;
  // Implemented bits
  localparam logic [15:0] MASK_EN4     = 16'h000E;
  localparam logic [15:0] MASK_PRIO0   = 16'h7777;
  localparam logic [15:0] MASK_PRIO1   = 16'h7770;
  localparam logic [15:0] MASK_PRIO2   = 16'h7777;
  localparam logic [15:0] MASK_PRIO3   = 16'h0077;
  localparam logic [15:0] MASK_PRIO4   = 16'h7777;
  // Power-on values
  localparam logic [15:0] RST_EN4      = 16'h0000;
  localparam logic [15:0] RST_PRIO0    = 16'h4444;
  localparam logic [15:0] RST_PRIO1    = 16'h4440;
  localparam logic [15:0] RST_PRIO2    = 16'h4444;
  localparam logic [15:0] RST_PRIO3    = 16'h0044;
  localparam logic [15:0] RST_PRIO4    = 16'h4444;
  // Field positions
  localparam int          POS_F3       = 12;
  localparam int          POS_F2       = 8;
  localparam int          POS_F1       = 4;
  localparam int          POS_F0       = 0;
  localparam int          POS_CHECKSUM = 3;
  localparam int          POS_SER2_ERR = 2;
  localparam int          POS_SER1_ERR = 1;
  localparam logic [2:0]  PRIO_OFF     = 3'h0;
endpackage : irq_prio_pkg

// File: irq_enable_priority_regs.sv
`timescale 1ns/1ns
module irq_enable_priority_regs (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt sources
  input  wire logic [19:0] src_flag,
  input  wire logic [16:0] src_en_ext,
  input  wire logic [8:0]  err_src_prio,
  // Request to the core
  output logic             irq_req_q,
  output logic [2:0]       irq_level_q,
  output logic [4:0]       irq_id_q
);

  logic [15:0] en4_q;
  logic [15:0] prio0_q;
  logic [15:0] prio1_q;
  logic [15:0] prio2_q;
  logic [15:0] prio3_q;
  logic [15:0] prio4_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        seen_q;

  // Effective level, zero when the source may not be presented
  function automatic logic [2:0] eff_level(input logic flag, input logic en,
                                           input logic [2:0] prio);
    eff_level = (flag && en) ? prio : irq_prio_pkg::PRIO_OFF; // [RL4] [RL11]
  endfunction : eff_level

  function automatic logic [2:0] fld(input logic [15:0] r, input int pos);
    fld = r[pos +: 3];
  endfunction : fld

  // Address decode
  wire logic hit_en4   = (paddr == irq_prio_pkg::OFF_EN4);
  wire logic hit_prio0 = (paddr == irq_prio_pkg::OFF_PRIO0);
  wire logic hit_prio1 = (paddr == irq_prio_pkg::OFF_PRIO1);
  wire logic hit_prio2 = (paddr == irq_prio_pkg::OFF_PRIO2);
  wire logic hit_prio3 = (paddr == irq_prio_pkg::OFF_PRIO3);
  wire logic hit_prio4 = (paddr == irq_prio_pkg::OFF_PRIO4);
  wire logic hit_any   = hit_en4 | hit_prio0 | hit_prio1 | hit_prio2
                       | hit_prio3 | hit_prio4;

  // One wait state: answer on the second access cycle
  wire logic access   = psel & penable;
  wire logic capture  = access & ~pready_q;
  wire logic wr_take  = access & pready_q & pwrite & hit_any;
  wire logic [15:0] wd = pwdata[15:0];

  wire logic [15:0] rd_mux =
      hit_en4   ? (en4_q   & irq_prio_pkg::MASK_EN4)   : // [RL1]
      hit_prio0 ? (prio0_q & irq_prio_pkg::MASK_PRIO0) : // [RL6]
      hit_prio1 ? (prio1_q & irq_prio_pkg::MASK_PRIO1) : // [RL7]
      hit_prio2 ? (prio2_q & irq_prio_pkg::MASK_PRIO2) : // [RL8]
      hit_prio3 ? (prio3_q & irq_prio_pkg::MASK_PRIO3) : // [RL9]
      hit_prio4 ? (prio4_q & irq_prio_pkg::MASK_PRIO4) : // [RL10]
      16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= capture;
      pslverr_q <= capture & ~hit_any;
      if (capture) begin
        prdata_q <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Masking on write keeps unimplemented bits at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en4_q   <= irq_prio_pkg::RST_EN4;   // [RL5]
      prio0_q <= irq_prio_pkg::RST_PRIO0; // [RL5]
      prio1_q <= irq_prio_pkg::RST_PRIO1;
      prio2_q <= irq_prio_pkg::RST_PRIO2;
      prio3_q <= irq_prio_pkg::RST_PRIO3;
      prio4_q <= irq_prio_pkg::RST_PRIO4;
    end else if (wr_take) begin
      if (hit_en4)   en4_q   <= wd & irq_prio_pkg::MASK_EN4;   // [RL2] [RL12]
      if (hit_prio0) prio0_q <= wd & irq_prio_pkg::MASK_PRIO0; // [RL12]
      if (hit_prio1) prio1_q <= wd & irq_prio_pkg::MASK_PRIO1;
      if (hit_prio2) prio2_q <= wd & irq_prio_pkg::MASK_PRIO2;
      if (hit_prio3) prio3_q <= wd & irq_prio_pkg::MASK_PRIO3;
      if (hit_prio4) prio4_q <= wd & irq_prio_pkg::MASK_PRIO4;
    end
  end

  // Source priorities, ids 0..16 from the groups, 17..19 error sources
  logic [2:0] prio_w [20];
  assign prio_w[0]  = fld(prio0_q, irq_prio_pkg::POS_F3); // timer_one_prio
  assign prio_w[1]  = fld(prio0_q, irq_prio_pkg::POS_F2); // compare_one_prio
  assign prio_w[2]  = fld(prio0_q, irq_prio_pkg::POS_F1); // capture_one_prio
  assign prio_w[3]  = fld(prio0_q, irq_prio_pkg::POS_F0); // ext_pin_zero_prio
  assign prio_w[4]  = fld(prio1_q, irq_prio_pkg::POS_F3); // timer_two_prio
  assign prio_w[5]  = fld(prio1_q, irq_prio_pkg::POS_F2); // compare_two_prio
  assign prio_w[6]  = fld(prio1_q, irq_prio_pkg::POS_F1); // capture_two_prio
  assign prio_w[7]  = fld(prio2_q, irq_prio_pkg::POS_F3); // serial1_receive_prio
  assign prio_w[8]  = fld(prio2_q, irq_prio_pkg::POS_F2); // sync_serial1_event_prio
  assign prio_w[9]  = fld(prio2_q, irq_prio_pkg::POS_F1); // sync_serial1_fault_prio
  assign prio_w[10] = fld(prio2_q, irq_prio_pkg::POS_F0); // timer_three_prio
  assign prio_w[11] = fld(prio3_q, irq_prio_pkg::POS_F1); // adc_done_prio
  assign prio_w[12] = fld(prio3_q, irq_prio_pkg::POS_F0); // serial1_transmit_prio
  assign prio_w[13] = fld(prio4_q, irq_prio_pkg::POS_F3); // pin_change_prio
  assign prio_w[14] = fld(prio4_q, irq_prio_pkg::POS_F2); // comparator_prio
  assign prio_w[15] = fld(prio4_q, irq_prio_pkg::POS_F1); // twowire1_master_prio
  assign prio_w[16] = fld(prio4_q, irq_prio_pkg::POS_F0); // twowire1_slave_prio
  assign prio_w[17] = err_src_prio[2:0];
  assign prio_w[18] = err_src_prio[5:3];
  assign prio_w[19] = err_src_prio[8:6];

  // Error sources take their enables from this block
  wire logic [19:0] en_all = {en4_q[irq_prio_pkg::POS_CHECKSUM], // [RL2]
                              en4_q[irq_prio_pkg::POS_SER2_ERR],
                              en4_q[irq_prio_pkg::POS_SER1_ERR],
                              src_en_ext};

  logic [2:0] lvl_w [20];
  for (genvar i = 0; i < 20; i++) begin : g_lvl
    assign lvl_w[i] = eff_level(src_flag[i], en_all[i], prio_w[i]);
  end

  // Strictly greater keeps the lowest id on a tie
  logic [2:0] win_lvl;
  logic [4:0] win_id;
  always_comb begin
    win_lvl = irq_prio_pkg::PRIO_OFF;
    win_id  = 5'h00;
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin
      if (lvl_w[i] > win_lvl) begin // [RL3] [RL11]
        win_lvl = lvl_w[i];
        win_id  = 5'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q   <= 1'b0;
      irq_level_q <= 3'h0;
      irq_id_q    <= 5'h00;
      seen_q      <= 1'b0;
    end else begin
      irq_req_q   <= (win_lvl != irq_prio_pkg::PRIO_OFF); // [RL4]
      irq_level_q <= win_lvl;
      irq_id_q    <= win_id;
      seen_q      <= 1'b1;
    end
  end

  property p_en4_rsv_zero;
    @(posedge pclk) disable iff (!presetn)
      capture && !pwrite && hit_en4 |=> prdata_q[15:4] == 12'h000 && !prdata_q[0];
  endproperty
  a_en4_rsv_zero: assert property (p_en4_rsv_zero) // [RL1]
    else $error("enable register reserved bits read nonzero");

  property p_en4_write;
    @(posedge pclk) disable iff (!presetn)
      wr_take && hit_en4 |=> en4_q[3:1] == $past(pwdata[3:1]) && en4_q[0] == 1'b0;
  endproperty
  a_en4_write: assert property (p_en4_write) // [RL2]
    else $error("enable bits did not take the written value");

  property p_level_nonzero;
    @(posedge pclk) disable iff (!presetn)
      irq_req_q |-> irq_level_q != 3'h0 && irq_level_q == $past(win_lvl);
  endproperty
  a_level_nonzero: assert property (p_level_nonzero) // [RL3]
    else $error("request level zero or not the winning level");

  property p_zero_prio_blocked;
    @(posedge pclk) disable iff (!presetn)
      prio0_q[14:12] == 3'h0 |=> !(irq_req_q && irq_id_q == 5'h00);
  endproperty
  a_zero_prio_blocked: assert property (p_zero_prio_blocked) // [RL4]
    else $error("source with priority 000 presented");

  property p_reset_values;
    @(posedge pclk) disable iff (!presetn)
      !seen_q |-> en4_q == 16'h0000 && prio0_q == 16'h4444 && prio3_q == 16'h0044;
  endproperty
  a_reset_values: assert property (p_reset_values) // [RL5]
    else $error("registers not at power-on values");

  property p_prio0_rsv;
    @(posedge pclk) disable iff (!presetn)
      capture && !pwrite && hit_prio0 |=> (prdata_q[15:0] & 16'h8888) == 16'h0000;
  endproperty
  a_prio0_rsv: assert property (p_prio0_rsv) // [RL6]
    else $error("group0 separator bits read nonzero");

  property p_prio1_rsv;
    @(posedge pclk) disable iff (!presetn)
      capture && !pwrite && hit_prio1 |=> (prdata_q[15:0] & 16'h888F) == 16'h0000;
  endproperty
  a_prio1_rsv: assert property (p_prio1_rsv) // [RL7]
    else $error("group1 unimplemented bits read nonzero");

  property p_prio2_write;
    @(posedge pclk) disable iff (!presetn)
      wr_take && hit_prio2 |=> prio2_q == ($past(pwdata[15:0]) & 16'h7777);
  endproperty
  a_prio2_write: assert property (p_prio2_write) // [RL8]
    else $error("group2 write not stored at field positions");

  property p_prio3_rsv;
    @(posedge pclk) disable iff (!presetn)
      capture && !pwrite && hit_prio3 |=> prdata_q[15:7] == 9'h000 && !prdata_q[3];
  endproperty
  a_prio3_rsv: assert property (p_prio3_rsv) // [RL9]
    else $error("group3 bits 15-7 read nonzero");

  property p_prio4_write;
    @(posedge pclk) disable iff (!presetn)
      wr_take && hit_prio4 |=> prio4_q == ($past(pwdata[15:0]) & 16'h7777);
  endproperty
  a_prio4_write: assert property (p_prio4_write) // [RL10]
    else $error("group4 write not stored at field positions");

  property p_winner_flagged;
    @(posedge pclk) disable iff (!presetn)
      irq_req_q |-> (($past(src_flag) >> irq_id_q) & 20'h00001) == 20'h00001;
  endproperty
  a_winner_flagged: assert property (p_winner_flagged) // [RL11]
    else $error("presented source had no flag");

  property p_no_write_stable;
    @(posedge pclk) disable iff (!presetn)
      !wr_take |=> $stable(prio1_q) && $stable(en4_q);
  endproperty
  a_no_write_stable: assert property (p_no_write_stable) // [RL12]
    else $error("register changed without a bus write");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready_q |=> !pready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) // [RL12]
    else $error("ready held longer than one cycle");

  property p_unmapped_ignored;
    @(posedge pclk) disable iff (!presetn)
      access && pready_q && pwrite && !hit_any |=> $stable(en4_q) && $stable(prio0_q);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored) // [RL12]
    else $error("write to an unmapped address changed a register");

  property p_idle_level_zero;
    @(posedge pclk) disable iff (!presetn)
      !irq_req_q |-> irq_level_q == 3'h0;
  endproperty
  a_idle_level_zero: assert property (p_idle_level_zero) // [RL4]
    else $error("level shown without a request");

  property p_ser1_err_blocked;
    @(posedge pclk) disable iff (!presetn)
      !en4_q[1] && src_flag == 20'h20000 |=> !irq_req_q;
  endproperty
  a_ser1_err_blocked: assert property (p_ser1_err_blocked) // [RL2]
    else $error("serial1 error presented while its enable is clear");

  property p_checksum_presented;
    @(posedge pclk) disable iff (!presetn)
      en4_q[3] && src_flag == 20'h80000 && err_src_prio[8:6] != 3'h0
        |=> irq_req_q && irq_id_q == 5'h13 && irq_level_q == $past(err_src_prio[8:6]);
  endproperty
  a_checksum_presented: assert property (p_checksum_presented) // [RL2]
    else $error("enabled checksum source not presented");

  property p_top_level_wins;
    @(posedge pclk) disable iff (!presetn)
      src_flag[3] && src_en_ext[3] && prio0_q[2:0] == 3'h7 |=> irq_req_q && irq_level_q == 3'h7;
  endproperty
  a_top_level_wins: assert property (p_top_level_wins) // [RL3]
    else $error("level seven source did not win");

  property p_prio0_write;
    @(posedge pclk) disable iff (!presetn)
      wr_take && hit_prio0 |=> prio0_q == ($past(pwdata[15:0]) & 16'h7777);
  endproperty
  a_prio0_write: assert property (p_prio0_write) // [RL6]
    else $error("group0 write not stored at field positions");

  property p_prio1_write;
    @(posedge pclk) disable iff (!presetn)
      wr_take && hit_prio1 |=> prio1_q == ($past(pwdata[15:0]) & 16'h7770);
  endproperty
  a_prio1_write: assert property (p_prio1_write) // [RL7]
    else $error("group1 write not stored at field positions");

  property p_prio3_write;
    @(posedge pclk) disable iff (!presetn)
      wr_take && hit_prio3 |=> prio3_q == ($past(pwdata[15:0]) & 16'h0077);
  endproperty
  a_prio3_write: assert property (p_prio3_write) // [RL9]
    else $error("group3 write not stored at field positions");

endmodule : irq_enable_priority_regs

// File: irq_src_model.sv
`timescale 1ns/1ns
module irq_src_model (
  // Clock
  input  wire logic        pclk,
  // Peripheral flags, outside enables and priorities
  output logic      [19:0] src_flag,
  output logic      [16:0] src_en_ext,
  output logic      [8:0]  err_src_prio
);
  initial begin
    src_flag     = 20'h00000;
    src_en_ext   = 17'h00000;
    err_src_prio = 9'h000;
  end
  // Peripherals change levels just after an edge, never mid-cycle
  task automatic drive(input logic [19:0] f, input logic [16:0] e, input logic [8:0] p);
    src_flag     <= f;
    src_en_ext   <= e;
    err_src_prio <= p;
    @(posedge pclk);
  endtask : drive
endmodule : irq_src_model

// File: tb.sv
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req_q, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  irq_level_q;
  logic [4:0]  irq_id_q;
  logic [19:0] src_flag;
  logic [16:0] src_en_ext;
  logic [8:0]  err_src_prio;
  logic [11:0] offs [6];
  logic [15:0] rsts [6];
  logic [15:0] msks [6];
  logic [15:0] pats [3];
  int          err_count, checked;

  irq_enable_priority_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_flag(src_flag), .src_en_ext(src_en_ext),
    .err_src_prio(err_src_prio), .irq_req_q(irq_req_q), .irq_level_q(irq_level_q),
    .irq_id_q(irq_id_q));
  irq_src_model m (.pclk(pclk), .src_flag(src_flag), .src_en_ext(src_en_ext),
    .err_src_prio(err_src_prio));

  task automatic close_out;
    $display("Counts: checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen at an edge; one idle edge after
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      close_out;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic irq_exp(input logic r, input logic [2:0] l, input logic [4:0] id);
    repeat (2) @(posedge pclk);
    chk({23'h0, irq_req_q, irq_level_q, irq_id_q}, {23'h0, r, l, id});
  endtask : irq_exp

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, {16'h0, rsts[i]});
    end
    irq_exp(1'b0, 3'h0, 5'h00);
    $display("Test reset values done");
  endtask : t_reset

  task automatic t_fields;
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 6; i++) begin
        apb(1'b1, offs[i], {16'hFFFF, pats[p]});
        apb(1'b0, offs[i], 32'h0);
        chk(rd, {16'h0, pats[p] & msks[i]});
        chk({31'h0, er}, 32'h0);
      end
    end
    apb(1'b1, 12'h018, 32'hFFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    $display("Test field access done");
  endtask : t_fields

  // Registers hold the written zeros here, so reset must visibly restore the priority fields (the enable register resets to zero too)
  task automatic t_reset_again;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
  endtask : t_reset_again

  task automatic t_arb;
    for (int i = 0; i < 6; i++) apb(1'b1, offs[i], {16'h0, rsts[i]});
    m.drive(20'h00008, 17'h00008, 9'h000);
    irq_exp(1'b1, 3'h4, 5'h03);
    m.drive(20'h00009, 17'h00000, 9'h000);
    irq_exp(1'b0, 3'h0, 5'h00);
    m.drive(20'h00009, 17'h00009, 9'h000);
    apb(1'b1, offs[1], 32'h1007);
    irq_exp(1'b1, 3'h7, 5'h03);
    apb(1'b1, offs[1], 32'h7001);
    irq_exp(1'b1, 3'h7, 5'h00);
    apb(1'b1, offs[1], 32'h0000);
    irq_exp(1'b0, 3'h0, 5'h00);
    // Each error source: blocked by the other enables, passed by its own bit
    for (int k = 0; k < 3; k++) begin
      m.drive(20'h20000 << k, 17'h00000, 9'h1FF);
      apb(1'b1, offs[0], {28'h0, ~(4'h2 << k) & 4'hE});
      irq_exp(1'b0, 3'h0, 5'h00);
      apb(1'b1, offs[0], {28'h0, 4'h2 << k});
      irq_exp(1'b1, 3'h7, 5'h11 + 5'(k));
    end
    m.drive(20'h00000, 17'h00000, 9'h000);
    $display("Test arbitration done");
  endtask : t_arb

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    checked = 0;
    offs = '{irq_prio_pkg::OFF_EN4, irq_prio_pkg::OFF_PRIO0, irq_prio_pkg::OFF_PRIO1,
             irq_prio_pkg::OFF_PRIO2, irq_prio_pkg::OFF_PRIO3, irq_prio_pkg::OFF_PRIO4};
    rsts = '{16'h0000, 16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h4444};
    msks = '{16'h000E, 16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7777};
    pats = '{16'hFFFF, 16'h1357, 16'h0000};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_fields;
    t_reset_again;
    t_arb;
    close_out;
  end
endmodule : tb
